//--- inc/plc_pkg.sv
// Constants for the loop control and tick timer block
//
// Overview of operation
// - Clock monitor enable writes ignored while self clock status is 1.
// - Enabled monitor turns slow or stopped oscillator into failure event.
// - Full stop mode disables loss detection regardless of monitor enable.
// - Loop power-on writes ignored while loop clock drives system clock.
// - Self clock mode powers loop; power-on bit reads its latched value.
// - Power-on bit one turns loop on, zero turns it off.
// - Loop-stops-in-wait forces automatic bandwidth to one, writes ignored.
// - Automatic bandwidth picks filter from nearness to target frequency.
// - Manual mode: acquisition bit one high bandwidth, zero low bandwidth.
// - Pseudo stop: tick timer runs if enabled, else freezes its count.
// - Pseudo stop: watchdog runs if enabled, else freezes its count.
// - Self clock enable written once; cannot clear during self clock mode.
// - Failure enters self clock mode if enabled, else monitor reset.
// - Any rate register write reinitialises tick counters; always accessible.
// - Prescale zero stops timer; codes one to seven give 2^10 to 2^16.
// - Modulus n divides by n+1; period is (n+1) times prescale.
// - Tick counters advance only on oscillator clock enable.
// - Each period end sets tick flag; write one clears; irq if enabled.
// - Self clock status reads one in self clock mode, else zero.
package plc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOOP_CTL = 8'h3A;
    localparam logic [7:0] IDX_TICK_RATE = 8'h3B;
    localparam logic [7:0] IDX_MODE_CTL = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [9:0] ADR_LOOP_CTL = {IDX_LOOP_CTL, 2'b00};
    localparam logic [9:0] ADR_TICK_RATE = {IDX_TICK_RATE, 2'b00};
    localparam logic [9:0] ADR_MODE_CTL = {IDX_MODE_CTL, 2'b00};
    localparam logic [9:0] ADR_STATUS = {IDX_STATUS, 2'b00};
    // Loop control fields
    localparam int B_CLK_MON = 7;
    localparam int B_PWR = 6;
    localparam int B_AUTO = 5;
    localparam int B_ACQUIRE = 4;
    localparam int B_TPS = 2;
    localparam int B_WPS = 1;
    localparam int B_SCE = 0;
    localparam logic [7:0] RST_LOOP_CTL = 8'hF1;
    localparam logic [7:0] RST_TICK_RATE = 8'h00;
    localparam logic [7:0] RST_MODE_CTL = 8'h00;
    // Mode control fields
    localparam int B_SEL = 7;
    localparam int B_PSS = 6;
    localparam int B_LSW = 3;
    localparam int B_TSW = 1;
    localparam int B_TIE = 0;
    // Status fields
    localparam int B_SCS = 7;
    localparam int B_LPW = 6;
    localparam int B_HBW = 5;
    localparam int B_MON = 4;
    localparam int B_TFL = 0;
    // Tick timer geometry
    localparam int PRE_W = 16;
    localparam int PRE_BASE = 9;
    localparam logic [3:0] MOD_ZERO = 4'h0;
endpackage

//--- rtl/plc_loop_tick.sv
// Loop control, clock fallback and tick timer with Avalon-MM registers
`timescale 1ns/1ps
module plc_loop_tick
    import plc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        osc_en_i,
    input  wire logic        osc_bad_i,
    input  wire logic        near_target_i,
    input  wire logic        stop_mode_i,
    input  wire logic        wait_mode_i,
    output logic             loop_power_o,
    output logic             high_bandwidth_o,
    output logic             monitor_reset_o,
    output logic             self_clock_o,
    output logic             tick_flag_o,
    output logic             tick_irq_o,
    output logic             watchdog_run_o
);

    //--------------------------------------------------------------
    // Bus slave
    //--------------------------------------------------------------
    logic        req;
    logic        acc;
    logic        wr;
    logic [7:0]  wd;
    logic [7:0]  loop_ctl;
    logic [7:0]  tick_rate;
    logic [7:0]  mode_ctl;
    logic        self_clock_status;
    logic        tick_flag;
    logic        sce_written;
    logic [7:0]  status;
    logic [7:0]  rd_mux;

    assign req = read_i | write_i;
    assign acc = req & ~waitrequest_o;
    assign wr = write_i & acc & byteenable_i[0];
    assign wd = writedata_i[7:0];

    // One wait state gives the read mux a full cycle to settle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            waitrequest_o <= 1'b1;
        else if (acc)
            waitrequest_o <= 1'b1;
        else if (req)
            waitrequest_o <= 1'b0;
    end

    always_comb
    begin
        case (address_i)
            ADR_LOOP_CTL:  rd_mux = loop_ctl;
            ADR_TICK_RATE: rd_mux = tick_rate;
            ADR_MODE_CTL:  rd_mux = mode_ctl;
            ADR_STATUS:    rd_mux = status;
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            readdata_o <= 32'h0000_0000;
        else if (read_i && waitrequest_o)
            readdata_o <= {24'h00_0000, rd_mux};
    end

    //--------------------------------------------------------------
    // Modes
    //--------------------------------------------------------------
    logic pseudo_stop;
    logic full_stop;
    logic monitor_active;
    logic failure;
    logic loop_sel_hold;

    assign pseudo_stop = stop_mode_i & mode_ctl[B_PSS];
    assign full_stop = stop_mode_i & ~mode_ctl[B_PSS];
    assign monitor_active = loop_ctl[B_CLK_MON] & ~full_stop;
    assign failure = monitor_active & osc_bad_i;
    // Loop clock is dropped on fallback, stop, or wait with loop stopping
    assign loop_sel_hold = self_clock_status | stop_mode_i
                         | (wait_mode_i & mode_ctl[B_LSW]);

    //--------------------------------------------------------------
    // Mode control register
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mode_ctl <= RST_MODE_CTL;
        else
        begin
            if (wr && address_i == ADR_MODE_CTL)
                mode_ctl <= wd & 8'hCB;
            if (loop_sel_hold)
                mode_ctl[B_SEL] <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Loop control register
    //--------------------------------------------------------------
    logic wr_loop;
    assign wr_loop = wr && address_i == ADR_LOOP_CTL;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            loop_ctl <= RST_LOOP_CTL;
            sce_written <= 1'b0;
        end
        else
        begin
            if (wr_loop)
            begin
                if (!self_clock_status)
                    loop_ctl[B_CLK_MON] <= wd[B_CLK_MON];
                if (!mode_ctl[B_SEL])
                    loop_ctl[B_PWR] <= wd[B_PWR];
                if (!mode_ctl[B_LSW])
                    loop_ctl[B_AUTO] <= wd[B_AUTO];
                loop_ctl[B_ACQUIRE] <= wd[B_ACQUIRE];
                loop_ctl[B_TPS] <= wd[B_TPS];
                loop_ctl[B_WPS] <= wd[B_WPS];
                if (!sce_written && !(self_clock_status && !wd[B_SCE]))
                    loop_ctl[B_SCE] <= wd[B_SCE];
                sce_written <= 1'b1;
            end
            if (mode_ctl[B_LSW])
                loop_ctl[B_AUTO] <= 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Fallback on oscillator failure
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            self_clock_status <= 1'b0;
        else if (failure && loop_ctl[B_SCE])
            self_clock_status <= 1'b1;
        // Exit follows the raw input, so a flickering oscillator toggles it
        else if (!osc_bad_i)
            self_clock_status <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            monitor_reset_o <= 1'b0;
        else
            monitor_reset_o <= failure & ~loop_ctl[B_SCE];
    end

    //--------------------------------------------------------------
    // Loop power and filter
    //--------------------------------------------------------------
    logic next_power;
    logic next_hbw;
    assign next_power = self_clock_status
                      | (loop_ctl[B_PWR] & ~stop_mode_i
                         & ~(wait_mode_i & mode_ctl[B_LSW]));
    assign next_hbw = loop_ctl[B_AUTO] ? ~near_target_i
                                       : loop_ctl[B_ACQUIRE];

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            loop_power_o <= 1'b0;
            high_bandwidth_o <= 1'b0;
            self_clock_o <= 1'b0;
        end
        else
        begin
            loop_power_o <= next_power;
            high_bandwidth_o <= next_hbw;
            self_clock_o <= self_clock_status;
        end
    end

    //--------------------------------------------------------------
    // Watchdog run enable
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            watchdog_run_o <= 1'b0;
        // Only the run enable lives here; the watchdog counter sits outside
        else
            watchdog_run_o <= osc_en_i & ~full_stop
                & ~(pseudo_stop & ~loop_ctl[B_WPS]);
    end

    //--------------------------------------------------------------
    // Tick timer
    //--------------------------------------------------------------
    logic [PRE_W-1:0] pre_cnt;
    logic [3:0]       mod_cnt;
    logic             tick_run;
    logic             tick_init;
    logic             pre_wrap;
    logic             tick_end;
    logic             wr_rate;

    // Last prescaler count for codes 1..7: 2^(code+9)-1
    function automatic logic [PRE_W-1:0] pre_last(input logic [2:0] code);
        pre_last = PRE_W'((32'h1 << (PRE_BASE + int'(code))) - 32'h1);
    endfunction

    assign wr_rate = wr && address_i == ADR_TICK_RATE;
    assign tick_init = wr_rate | (wait_mode_i & mode_ctl[B_TSW]);
    // Frozen, not cleared, in pseudo stop: resumes mid-period
    assign tick_run = osc_en_i & (tick_rate[6:4] != 3'b000)
                    & ~full_stop
                    & ~(pseudo_stop & ~loop_ctl[B_TPS]);
    assign pre_wrap = tick_run & (pre_cnt == pre_last(tick_rate[6:4]));
    assign tick_end = pre_wrap & (mod_cnt == tick_rate[3:0]);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tick_rate <= RST_TICK_RATE;
        else if (wr_rate)
            tick_rate <= wd & 8'h7F;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pre_cnt <= '0;
            mod_cnt <= MOD_ZERO;
        end
        else if (tick_init)
        begin
            pre_cnt <= '0;
            mod_cnt <= MOD_ZERO;
        end
        else if (pre_wrap)
        begin
            pre_cnt <= '0;
            mod_cnt <= tick_end ? MOD_ZERO : mod_cnt + 4'h1;
        end
        else if (tick_run)
            pre_cnt <= pre_cnt + PRE_W'(1);
    end

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tick_flag <= 1'b0;
        else if (tick_end && !tick_init)
            tick_flag <= 1'b1;
        else if (wr && address_i == ADR_STATUS && wd[B_TFL])
            tick_flag <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tick_flag_o <= 1'b0;
            tick_irq_o <= 1'b0;
        end
        else
        begin
            tick_flag_o <= tick_flag;
            tick_irq_o <= tick_flag & mode_ctl[B_TIE];
        end
    end

    assign status = {self_clock_status, loop_power_o, high_bandwidth_o,
                     monitor_active, 3'b000, tick_flag};

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_monitor_locked;
        wr_loop && self_clock_status |=> $stable(loop_ctl[B_CLK_MON]);
    endproperty
    a_monitor_locked: assert property (p_monitor_locked)
        else $error("monitor enable changed in self clock");

    property p_no_detect_stop;
        full_stop |-> !failure ##1 !monitor_reset_o;
    endproperty
    a_no_detect_stop: assert property (p_no_detect_stop)
        else $error("loss detected in full stop");

    property p_pwr_locked;
        wr_loop && mode_ctl[B_SEL] |=> $stable(loop_ctl[B_PWR]);
    endproperty
    a_pwr_locked: assert property (p_pwr_locked)
        else $error("power bit changed while loop selected");

    property p_self_clock_power;
        self_clock_status |=> loop_power_o;
    endproperty
    a_self_clock_power: assert property (p_self_clock_power)
        else $error("loop unpowered in self clock");

    property p_auto_forced;
        mode_ctl[B_LSW] |=> loop_ctl[B_AUTO];
    endproperty
    a_auto_forced: assert property (p_auto_forced)
        else $error("auto bit not forced");

    property p_manual_filter;
        !loop_ctl[B_AUTO] |=> high_bandwidth_o == $past(loop_ctl[B_ACQUIRE]);
    endproperty
    a_manual_filter: assert property (p_manual_filter)
        else $error("manual filter mismatch");

    property p_tick_freeze;
        pseudo_stop && !loop_ctl[B_TPS] && !tick_init
            |=> $stable(pre_cnt) && $stable(mod_cnt);
    endproperty
    a_tick_freeze: assert property (p_tick_freeze)
        else $error("tick counters moved in pseudo stop");

    property p_fail_reset;
        failure && !loop_ctl[B_SCE] |=> monitor_reset_o ##0 !self_clock_o;
    endproperty
    a_fail_reset: assert property (p_fail_reset)
        else $error("failure without monitor reset");

    property p_rate_init;
        wr_rate |=> pre_cnt == '0 && mod_cnt == MOD_ZERO;
    endproperty
    a_rate_init: assert property (p_rate_init)
        else $error("rate write did not reinit");

    property p_off_hold;
        tick_rate[6:4] == 3'b000 |-> !tick_end;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("tick in off state");

    property p_flag_set;
        tick_end && !tick_init |=> tick_flag ##1 tick_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("tick flag not set");

    // Main scenarios: tick with interrupt, fallback, reset, freeze, bus
    c_tick: cover property (tick_end ##[1:20] tick_irq_o);
    c_self_clock: cover property (failure && loop_ctl[B_SCE]
        ##2 self_clock_o);
    c_mon_reset: cover property (failure && !loop_ctl[B_SCE]
        ##1 monitor_reset_o);
    c_freeze: cover property (pseudo_stop && !loop_ctl[B_TPS]
        && pre_cnt != '0);
    c_bus: cover property (read_i && !waitrequest_o);

endmodule

//--- verif/testbench.sv
// Self-checking bench for the loop control and tick timer block
`timescale 1ns/1ps
module testbench;
    import plc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_b_i;
    logic [9:0]  address_i;
    logic        read_i;
    logic        write_i;
    logic [3:0]  byteenable_i;
    logic [31:0] writedata_i;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        osc_en_i;
    logic        osc_bad_i;
    logic        near_target_i;
    logic        stop_mode_i;
    logic        wait_mode_i;
    logic        loop_power_o;
    logic        high_bandwidth_o;
    logic        monitor_reset_o;
    logic        self_clock_o;
    logic        tick_flag_o;
    logic        tick_irq_o;
    logic        watchdog_run_o;
    int          fail_count;
    int          checked;
    int          seed;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    logic [7:0]  rnd;

    plc_loop_tick u_dut (
        .clk_i            (clk_i),
        .rst_b_i          (rst_b_i),
        .address_i        (address_i),
        .read_i           (read_i),
        .write_i          (write_i),
        .byteenable_i     (byteenable_i),
        .writedata_i      (writedata_i),
        .readdata_o       (readdata_o),
        .waitrequest_o    (waitrequest_o),
        .osc_en_i         (osc_en_i),
        .osc_bad_i        (osc_bad_i),
        .near_target_i    (near_target_i),
        .stop_mode_i      (stop_mode_i),
        .wait_mode_i      (wait_mode_i),
        .loop_power_o     (loop_power_o),
        .high_bandwidth_o (high_bandwidth_o),
        .monitor_reset_o  (monitor_reset_o),
        .self_clock_o     (self_clock_o),
        .tick_flag_o      (tick_flag_o),
        .tick_irq_o       (tick_irq_o),
        .watchdog_run_o   (watchdog_run_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic [9:0] a, input logic rd,
                       input logic [7:0] d);
        int n;
        n = 0;
        address_i   <= a;
        writedata_i <= {24'h000000, d};
        read_i      <= rd;
        write_i     <= ~rd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 20);
        read_i  <= 1'b0;
        write_i <= 1'b0;
        // One idle edge so a following call never re-drives a strobe at once
        @(posedge clk_i);
        if (n >= 20)
        begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b0, d);
    endtask

    // Expected value and mask are noted before the read is issued
    task automatic rd(input logic [9:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        exp_q.push_back({e & m, m});
        bus(a, 1'b1, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Read monitor: oldest note against each accepted read
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (read_i === 1'b1 && waitrequest_o === 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                fail_count++;
            end
            else
            begin
                note = exp_q.pop_front();
                check(readdata_o & {24'hFFFFFF, note[7:0]},
                      {24'h000000, note[15:8]});
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h6db7a9e9;
        fail_count = 0;
        checked = 0;
        rst_b_i = 1'b0;
        address_i = 10'h000;
        read_i = 1'b0;
        write_i = 1'b0;
        byteenable_i = 4'hF;
        writedata_i = 32'h00000000;
        osc_en_i = 1'b0;
        osc_bad_i = 1'b0;
        near_target_i = 1'b0;
        stop_mode_i = 1'b0;
        wait_mode_i = 1'b0;
        cyc(8);
        rst_b_i <= 1'b1;
        cyc(1);
        rd(ADR_LOOP_CTL, RST_LOOP_CTL, 8'hFF);
        rd(ADR_TICK_RATE, RST_TICK_RATE, 8'hFF);
        rd(ADR_MODE_CTL, RST_MODE_CTL, 8'hFF);
        rd(10'h000, 8'h00, 8'hFF);
        repeat (6)
        begin
            rnd = 8'($random(seed));
            wr(ADR_TICK_RATE, rnd);
            rd(ADR_TICK_RATE, rnd & 8'h7F, 8'hFF);
        end
        wr(ADR_TICK_RATE, 8'h00);
        // Low byte lane disabled: the write must be dropped
        byteenable_i <= 4'hE;
        wr(ADR_TICK_RATE, 8'h55);
        byteenable_i <= 4'hF;
        rd(ADR_TICK_RATE, 8'h00, 8'hFF);
        // Manual filter choice; first write consumes the once-only bit
        wr(ADR_LOOP_CTL, 8'hD1);
        rd(ADR_STATUS, 8'h20, 8'h20);
        wr(ADR_LOOP_CTL, 8'hC0);
        rd(ADR_LOOP_CTL, 8'hC1, 8'hFF);
        rd(ADR_STATUS, 8'h00, 8'h20);
        wr(ADR_LOOP_CTL, 8'hF1);
        repeat (4)
        begin
            rnd = 8'($random(seed));
            near_target_i <= rnd[0];
            cyc(3);
            rd(ADR_STATUS, {2'b00, ~rnd[0], 5'b00000}, 8'h20);
        end
        wr(ADR_LOOP_CTL, 8'hC1);
        wr(ADR_MODE_CTL, 8'h08);
        rd(ADR_LOOP_CTL, 8'hE1, 8'hFF);
        wr(ADR_LOOP_CTL, 8'hC1);
        rd(ADR_LOOP_CTL, 8'hE1, 8'hFF);
        wait_mode_i <= 1'b1;
        cyc(3);
        rd(ADR_STATUS, 8'h00, 8'h40);
        wait_mode_i <= 1'b0;
        wr(ADR_MODE_CTL, 8'h00);
        wr(ADR_LOOP_CTL, 8'h81);
        rd(ADR_STATUS, 8'h00, 8'h40);
        wr(ADR_LOOP_CTL, 8'hC1);
        rd(ADR_STATUS, 8'h40, 8'h40);
        wr(ADR_MODE_CTL, 8'h80);
        wr(ADR_LOOP_CTL, 8'h81);
        rd(ADR_LOOP_CTL, 8'hC1, 8'hFF);
        wr(ADR_MODE_CTL, 8'h00);
        // Oscillator failure with fallback enabled and loop bit cleared
        wr(ADR_LOOP_CTL, 8'h81);
        osc_bad_i <= 1'b1;
        cyc(5);
        rd(ADR_STATUS, 8'hC0, 8'hC0);
        check(self_clock_o, 1'b1);
        rd(ADR_LOOP_CTL, 8'h81, 8'hFF);
        wr(ADR_LOOP_CTL, 8'h01);
        rd(ADR_LOOP_CTL, 8'h81, 8'hFF);
        osc_bad_i <= 1'b0;
        cyc(5);
        rd(ADR_STATUS, 8'h00, 8'hC0);
        wr(ADR_LOOP_CTL, 8'h01);
        rd(ADR_LOOP_CTL, 8'h01, 8'hFF);
        osc_bad_i <= 1'b1;
        cyc(5);
        rd(ADR_STATUS, 8'h00, 8'h80);
        osc_bad_i <= 1'b0;
        // Full stop hides the failure even with the monitor on
        wr(ADR_LOOP_CTL, 8'h81);
        stop_mode_i <= 1'b1;
        osc_bad_i <= 1'b1;
        cyc(5);
        rd(ADR_STATUS, 8'h00, 8'h80);
        check(monitor_reset_o, 1'b0);
        osc_bad_i <= 1'b0;
        cyc(2);
        stop_mode_i <= 1'b0;
        // Tick timer: off code, oscillator gating, reinit, period
        wr(ADR_TICK_RATE, 8'h0F);
        osc_en_i <= 1'b1;
        cyc(3000);
        rd(ADR_STATUS, 8'h00, 8'h01);
        wr(ADR_TICK_RATE, 8'h11);
        osc_en_i <= 1'b0;
        cyc(2500);
        rd(ADR_STATUS, 8'h00, 8'h01);
        osc_en_i <= 1'b1;
        wr(ADR_TICK_RATE, 8'h11);
        cyc(1500);
        wr(ADR_TICK_RATE, 8'h11);
        cyc(1900);
        rd(ADR_STATUS, 8'h00, 8'h01);
        cyc(300);
        rd(ADR_STATUS, 8'h01, 8'h01);
        check(tick_flag_o, 1'b1);
        wr(ADR_MODE_CTL, 8'h01);
        cyc(3);
        check(tick_irq_o, 1'b1);
        wr(ADR_STATUS, 8'h01);
        rd(ADR_STATUS, 8'h00, 8'h01);
        // Pseudo stop with both run bits clear: counts hold, not reset
        wr(ADR_MODE_CTL, 8'h41);
        wr(ADR_LOOP_CTL, 8'h81);
        wr(ADR_TICK_RATE, 8'h11);
        cyc(1000);
        stop_mode_i <= 1'b1;
        cyc(5);
        check(watchdog_run_o, 1'b0);
        cyc(2000);
        rd(ADR_STATUS, 8'h00, 8'h01);
        wr(ADR_LOOP_CTL, 8'h83);
        cyc(3);
        check(watchdog_run_o, 1'b1);
        stop_mode_i <= 1'b0;
        cyc(900);
        rd(ADR_STATUS, 8'h00, 8'h01);
        cyc(300);
        rd(ADR_STATUS, 8'h01, 8'h01);
        // Second reset, fallback disabled: failure gives monitor reset
        rst_b_i <= 1'b0;
        cyc(3);
        rst_b_i <= 1'b1;
        cyc(1);
        rd(ADR_LOOP_CTL, RST_LOOP_CTL, 8'hFF);
        wr(ADR_LOOP_CTL, 8'h80);
        rd(ADR_LOOP_CTL, 8'h80, 8'hFF);
        osc_bad_i <= 1'b1;
        cyc(5);
        check(monitor_reset_o, 1'b1);
        check(self_clock_o, 1'b0);
        osc_bad_i <= 1'b0;
        cyc(5);
        if (exp_q.size() != 0)
            fail_count++;
        summarize();
    end
endmodule
